//--- pdm_mic_link.sv
// Digital side of a one-bit modulated microphone on a shared data line.
// Assumes the codec drives bitClk and a modulator clocked by bitClk
// supplies modBit; the bench resolves the data wire from its enable.
//
// Function
// - Strap high gives left, low gives right.
// - Sleep when bit clock below 200 kHz.
// - Data pin released throughout sleep.
// - Output starts 7 ms after clock returns.
// - Output settles 7 ms after power and clock.
// - Left drives on falling, right on rising.
// - Release line after own half period.
// - Strap captured once at power-up only.
// - Low power listening at 768 kHz clock.
`timescale 1ns/1ps
`include "pdm_mic_cfg.svh"

module pdm_mic_link #(
	parameter int WAKE_CYC = `PDM_WAKE_CYC,
	parameter int GAP_W    = 11,
	parameter int WAKE_W   = 21
) (
	// System clock and power-up reset.
	input  wire logic                clock,
	input  wire logic                nrst,
	// Bit clock from the codec.
	input  wire logic                bitClk,
	// Channel strap pin and modulator bit.
	input  wire logic                selectPin,
	input  wire logic                modBit,
	// Shared data line, driven while the enable is high.
	output logic                     pdmDataOut,
	output logic                     pdmDataOe,
	// Mode and channel status.
	output pdm_mic_pkg::mic_status_t micStatus
);
	import pdm_mic_pkg::*;

	localparam logic [GAP_W-1:0] SLEEP_GAP = GAP_W'(`PDM_SLEEP_GAP);
	localparam logic [GAP_W-1:0] LP_GAP    = GAP_W'(`PDM_LP_GAP);
	localparam logic [WAKE_W-1:0] WAKE_END = WAKE_W'(WAKE_CYC - 1);

	// System domain state.
	logic              selMeta_reg;
	logic              selSync_reg;
	logic              togMeta_reg;
	logic              togSync_reg;
	logic              togPrev_reg;
	logic [1:0]        strapCnt_reg;
	logic [1:0]        strapCnt_next;
	logic              strapTaken_reg;
	logic              strapTaken_next;
	logic              leftSide_reg;
	logic              leftSide_next;
	logic [GAP_W-1:0]  gapCnt_reg;
	logic [GAP_W-1:0]  gapCnt_next;
	logic              lowPower_reg;
	logic              lowPower_next;
	wake_state_t       state_reg;
	wake_state_t       state_next;
	logic [WAKE_W-1:0] wakeCnt_reg;
	logic [WAKE_W-1:0] wakeCnt_next;
	logic              outputOn_reg;
	logic              outputOn_next;
	logic              clkEdge;
	logic              clkSlow;
	logic              takeStrap;

	// Link domain state.
	logic              edgeTog_reg;
	logic              onMeta_reg;
	logic              onSync_reg;
	logic              leftMeta_reg;
	logic              leftSync_reg;
	logic              riseTog_reg;
	logic              fallTog_reg;
	logic              rightBit_reg;
	logic              leftBit_reg;
	logic              highHalf;

	// Two-stage synchronisers for the strap pin and the edge toggle.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			selMeta_reg <= 1'h0;
			selSync_reg <= 1'h0;
			togMeta_reg <= 1'h0;
			togSync_reg <= 1'h0;
			togPrev_reg <= 1'h0;
		end else begin
			selMeta_reg <= selectPin;
			selSync_reg <= selMeta_reg;
			togMeta_reg <= edgeTog_reg;
			togSync_reg <= togMeta_reg;
			togPrev_reg <= togSync_reg;
		end
	end

	// One pulse per bit clock rising edge, seen in the system domain.
	assign clkEdge = togSync_reg ^ togPrev_reg;
	assign clkSlow = (gapCnt_reg == SLEEP_GAP);
	assign takeStrap = !strapTaken_reg &&
		(strapCnt_reg == `PDM_STRAP_SETTLE);

	// Strap is taken once, after the synchroniser has filled.
	always_comb begin
		strapCnt_next   = strapCnt_reg;
		strapTaken_next = strapTaken_reg;
		leftSide_next   = leftSide_reg;
		if (!strapTaken_reg) begin
			strapCnt_next = strapCnt_reg + 2'h1;
		end
		if (takeStrap) begin
			strapTaken_next = 1'h1;
			leftSide_next = (selSync_reg == `PDM_LEFT_STRAP);
		end
	end

	// Registers of the strap capture.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			strapCnt_reg   <= 2'h0;
			strapTaken_reg <= 1'h0;
			leftSide_reg   <= 1'h0;
		end else begin
			strapCnt_reg   <= strapCnt_next;
			strapTaken_reg <= strapTaken_next;
			leftSide_reg   <= leftSide_next;
		end
	end

	// Clock period monitor and sleep, wake and active sequencing.
	always_comb begin
		gapCnt_next   = gapCnt_reg;
		lowPower_next = lowPower_reg;
		state_next    = state_reg;
		wakeCnt_next  = wakeCnt_reg;
		if (clkEdge) begin
			gapCnt_next = '0;
			lowPower_next = (gapCnt_reg >= LP_GAP);
		end else if (!clkSlow) begin
			gapCnt_next = gapCnt_reg + GAP_W'(1);
		end
		case (state_reg)
			ST_SLEEP: begin
				lowPower_next = 1'h0;
				if (clkEdge) begin
					state_next = ST_WAKING;
					wakeCnt_next = '0;
				end
			end
			ST_WAKING: begin
				if (clkSlow) begin
					state_next = ST_SLEEP;
				end else if (wakeCnt_reg == WAKE_END) begin
					state_next = ST_ACTIVE;
				end else begin
					wakeCnt_next = wakeCnt_reg + WAKE_W'(1);
				end
			end
			ST_ACTIVE: begin
				if (clkSlow) begin
					state_next = ST_SLEEP;
				end
			end
			default: begin
				state_next = ST_SLEEP;
			end
		endcase
		outputOn_next = (state_next == ST_ACTIVE);
	end

	// Registers of the monitor; the power-up state is sleep.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			gapCnt_reg   <= '0;
			lowPower_reg <= 1'h0;
			state_reg    <= ST_SLEEP;
			wakeCnt_reg  <= '0;
			outputOn_reg <= 1'h0;
		end else begin
			gapCnt_reg   <= gapCnt_next;
			lowPower_reg <= lowPower_next;
			state_reg    <= state_next;
			wakeCnt_reg  <= wakeCnt_next;
			outputOn_reg <= outputOn_next;
		end
	end

	// Status outputs: sleeping is decoded from state_reg, the other three come straight from registers.
	assign micStatus.sleeping          = (state_reg == ST_SLEEP);
	assign micStatus.lowPowerListening = lowPower_reg;
	assign micStatus.outputOn          = outputOn_reg;
	assign micStatus.leftSide          = leftSide_reg;

	// Rising edge work: edge toggle, level synchronisers, right bit.
	always_ff @(posedge bitClk or negedge nrst) begin
		if (!nrst) begin
			edgeTog_reg  <= 1'h0;
			onMeta_reg   <= 1'h0;
			onSync_reg   <= 1'h0;
			leftMeta_reg <= 1'h0;
			leftSync_reg <= 1'h0;
			riseTog_reg  <= 1'h0;
			rightBit_reg <= 1'h0;
		end else begin
			edgeTog_reg  <= !edgeTog_reg;
			onMeta_reg   <= outputOn_reg;
			onSync_reg   <= onMeta_reg;
			leftMeta_reg <= leftSide_reg;
			leftSync_reg <= leftMeta_reg;
			riseTog_reg  <= !riseTog_reg;
			rightBit_reg <= modBit;
		end
	end

	// Falling edge work: close the high half and load the left bit.
	always_ff @(negedge bitClk or negedge nrst) begin
		if (!nrst) begin
			fallTog_reg <= 1'h0;
			leftBit_reg <= 1'h0;
		end else begin
			fallTog_reg <= riseTog_reg;
			leftBit_reg <= modBit;
		end
	end

	// High from a rising edge to the next falling edge.
	assign highHalf = riseTog_reg ^ fallTog_reg;

	// Each side drives only its own half and floats in the other.
	// The system flop also gates the enable, because a stopped bit
	// clock would otherwise freeze the link copy of outputOn.
	assign pdmDataOut = leftSync_reg ? leftBit_reg : rightBit_reg;
	assign pdmDataOe  = outputOn_reg && onSync_reg &&
		(leftSync_reg ? !highHalf : highHalf);

	// Checks in the system domain.
	sequence seqWakeEnd;
		state_reg == ST_WAKING && wakeCnt_reg == WAKE_END && !clkSlow;
	endsequence

	sequence seqSleepEntry;
		state_reg != ST_SLEEP && clkSlow;
	endsequence

	property pWakeToActive;
		@(posedge clock) disable iff (!nrst)
		seqWakeEnd |=> state_reg == ST_ACTIVE ##0 outputOn_reg;
	endproperty

	property pSlowSleeps;
		@(posedge clock) disable iff (!nrst)
		seqSleepEntry |=> state_reg == ST_SLEEP ##1 !pdmDataOe;
	endproperty

	a_wake_to_active: assert property (pWakeToActive)
		else $error("Wake end did not enable output.");

	a_slow_clock_sleeps: assert property (pSlowSleeps)
		else $error("Slow bit clock did not enter sleep.");

	a_sleep_released: assert property (
		@(posedge clock) disable iff (!nrst)
		state_reg == ST_SLEEP |-> !pdmDataOe)
		else $error("Data line driven during sleep.");

	a_output_after_wait: assert property (
		@(posedge clock) disable iff (!nrst)
		$rose(outputOn_reg) |-> $past(state_reg) == ST_WAKING &&
			$past(wakeCnt_reg) == WAKE_END)
		else $error("Output began before the wake time.");

	a_strap_frozen: assert property (
		@(posedge clock) disable iff (!nrst)
		strapTaken_reg |=> $stable(leftSide_reg) && strapTaken_reg)
		else $error("Channel strap changed after capture.");

	a_strap_sets_side: assert property (
		@(posedge clock) disable iff (!nrst)
		takeStrap |=> leftSide_reg == $past(selSync_reg))
		else $error("Channel side differs from strap level.");

	a_low_power_band: assert property (
		@(posedge clock) disable iff (!nrst)
		clkEdge && state_reg != ST_SLEEP |=>
			lowPower_reg == ($past(gapCnt_reg) >= LP_GAP))
		else $error("Low power mode does not follow clock rate.");

	// Checks at the falling edge see the level of the high half.
	a_right_high_half: assert property (
		@(negedge bitClk) disable iff (!nrst)
		outputOn_reg && onSync_reg && !leftSync_reg |-> pdmDataOe)
		else $error("Right side not driving in the high half.");

	a_left_released: assert property (
		@(negedge bitClk) disable iff (!nrst)
		leftSync_reg |-> !pdmDataOe)
		else $error("Left side drove during the high half.");

endmodule

//--- pdm_mic_cfg.svh
// Timing and strap constants for the microphone link block.
// Assumes a 200 MHz system clock; included by its bare name.
`ifndef PDM_MIC_CFG_SVH
`define PDM_MIC_CFG_SVH

// System clock rate in kHz.
`define PDM_SYS_CLK_KHZ 200000
// Bit clock below this rate puts the microphone to sleep.
`define PDM_SLEEP_KHZ 200
// Longest bit clock period, in system cycles, before sleep.
`define PDM_SLEEP_GAP (`PDM_SYS_CLK_KHZ / `PDM_SLEEP_KHZ)
// Nominal low power listening rate and accepted margin above it.
`define PDM_LP_KHZ 768
`define PDM_LP_MARGIN_PCT 125
// Shortest period, in system cycles, still taken as low power.
`define PDM_LP_GAP \
	((`PDM_SYS_CLK_KHZ * 100) / (`PDM_LP_KHZ * `PDM_LP_MARGIN_PCT))
// Wake-up and start-up time in ms, and in system cycles.
`define PDM_WAKE_MS 7
`define PDM_WAKE_CYC (`PDM_WAKE_MS * `PDM_SYS_CLK_KHZ)
// Cycles after reset release before the strap is taken.
`define PDM_STRAP_SETTLE 2'h3
// Strap level that selects the left channel.
`define PDM_LEFT_STRAP 1'h1

`endif

//--- pdm_mic_pkg.sv
// Types shared by the microphone link block.
// Assumes nothing of its surroundings.
package pdm_mic_pkg;

	// Power state of the microphone.
	typedef enum logic [1:0] {
		ST_SLEEP,
		ST_WAKING,
		ST_ACTIVE
	} wake_state_t;

	// Status seen by the rest of the chip.
	typedef struct packed {
		logic sleeping;
		logic lowPowerListening;
		logic outputOn;
		logic leftSide;
	} mic_status_t;

endpackage

//--- pdm_codec_model.sv
// Codec model: sources the bit clock and modulator bit, resolves the line.
// Assumes the bench sets the half period and feeds random bits.
`timescale 1ns/1ps

module pdm_codec_model (
	// Bench control.
	input  wire logic        run,
	input  wire logic [15:0] halfNs,
	input  wire logic        rndBit,
	// Microphone pin.
	input  wire logic        dataOut,
	input  wire logic        dataOe,
	// Link side.
	output logic             bitClk,
	output logic             modBit,
	output logic             line
);
	logic lastDriven = 1'b0;

	// The clock runs only while enabled and rests low between runs.
	// A started high half is always finished, so a stop never leaves a
	// zero-width pulse that would clock the link flops out of step.
	initial begin
		bitClk = 1'b0;
		forever begin
			if (run || bitClk) begin
				#(halfNs);
				if (run || bitClk) begin
					bitClk = ~bitClk;
				end
			end else begin
				#7;
			end
		end
	end

	// A new modulator bit comes a quarter period after each edge.
	initial modBit = 1'b0;
	always @(bitClk) begin
		#(halfNs / 2) modBit = rndBit;
	end

	// No pull resistor, so a released line shows the inverse level.
	always @(dataOut or dataOe) begin
		if (dataOe) begin
			lastDriven = dataOut;
		end
	end
	assign line = dataOe ? dataOut : ~lastDriven;
endmodule

//--- pdm_mic_link_tb.sv
// Bench for the microphone link: codec model, reference model, checks.
// Assumes the design package and the codec model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin errTotal++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module pdm_mic_link_tb;
	import pdm_mic_pkg::*;
	localparam int WAKE = 50;

	logic        clock;
	logic        nrst;
	logic        run;
	logic [15:0] halfNs;
	logic        rndBit;
	logic        selectPin;
	logic        bitClk;
	logic        modBit;
	logic        line;
	logic        pdmDataOut;
	logic        pdmDataOe;
	mic_status_t micStatus;
	logic [31:0] rndState = 32'h0000_001A;
	logic        leftExp;
	logic        expBit;
	logic        lvl;
	logic        got;
	logic        expQ[$];
	int          onRises = 0;
	int          errTotal = 0;
	int          cmpCount = 0;
	int          n;

	pdm_mic_link #(.WAKE_CYC(WAKE)) pdm_mic_link_inst (
		.clock(clock), .nrst(nrst), .bitClk(bitClk), .selectPin(selectPin),
		.modBit(modBit), .pdmDataOut(pdmDataOut), .pdmDataOe(pdmDataOe),
		.micStatus(micStatus));
	pdm_codec_model pdm_codec_model_inst (
		.run(run), .halfNs(halfNs), .rndBit(rndBit), .dataOut(pdmDataOut),
		.dataOe(pdmDataOe), .bitClk(bitClk), .modBit(modBit), .line(line));

	// System clock of 5 ns.
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// A fresh random modulator bit every system cycle.
	always @(posedge clock) begin
		rndState <= xorshift(rndState);
		rndBit <= rndState[0];
	end

	// Counts rises seen since the output was switched on.
	always @(posedge bitClk) begin
		onRises <= (micStatus.outputOn === 1'b1) ? onRises + 1 : 0;
	end

	// Reference model: the own edge loads a bit that must stand on the
	// line, and the other half must be released. Channels split by edge.
	always @(bitClk) begin : watch
		lvl = bitClk;
		expBit = modBit;
		#(halfNs * 3 / 4);
		if (bitClk === lvl && run === 1'b1) begin
			if (lvl === ~leftExp) begin
				if (onRises >= 3 && micStatus.outputOn === 1'b1) begin
					expQ.push_back(expBit);
					`CHK(pdmDataOe, 1'b1)
					got = expQ.pop_front();
					`CHK(line, got)
				end else if (micStatus.outputOn !== 1'b1) begin
					`CHK(pdmDataOe, 1'b0)
				end
			end else begin
				`CHK(pdmDataOe, 1'b0)
			end
		end
	end

	task automatic conclude();
		$display("Compares %0d, mismatches %0d", cmpCount, errTotal);
		if (errTotal == 0 && cmpCount > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Starts the clock and times the wake-up from its first rise.
	task automatic wakeUp();
		n = 0;
		run <= 1'b1;
		while (bitClk !== 1'b1 && n < 400) begin
			@(posedge clock);
			n++;
		end
		`CHK(bitClk, 1'b1)
		if (bitClk !== 1'b1) conclude();
		n = 0;
		// Sampled on the falling edge, where the status has settled.
		while (micStatus.outputOn !== 1'b1 && n < WAKE + 40) begin
			@(negedge clock);
			n++;
		end
		`CHK(n >= WAKE && n <= WAKE + 8, 1'b1)
		if (n >= WAKE + 40) conclude();
		repeat (400) @(posedge clock);
		$display("Wake test done after %0d cycles", n);
	endtask

	// Stops the clock long enough for the microphone to sleep.
	task automatic sleepNow();
		run <= 1'b0;
		repeat (1100) @(posedge clock);
		`CHK(micStatus.sleeping, 1'b1)
		`CHK(micStatus.lowPowerListening, 1'b0)
		`CHK(pdmDataOe, 1'b0)
		$display("Sleep test done");
	endtask

	// Main sequence: right side, sleep, low power, then left side.
	initial begin
		nrst = 1'b0;
		run = 1'b0;
		halfNs = 16'h000F;
		selectPin = 1'b0;
		leftExp = 1'b0;
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		repeat (6) @(posedge clock);
		`CHK(micStatus, 4'h8)
		wakeUp();
		`CHK(micStatus.lowPowerListening, 1'b0)
		selectPin <= 1'b1;
		repeat (400) @(posedge clock);
		`CHK(micStatus.leftSide, 1'b0)
		sleepNow();
		halfNs <= 16'h028B;
		wakeUp();
		`CHK(micStatus.lowPowerListening, 1'b1)
		sleepNow();
		halfNs <= 16'h000F;
		nrst <= 1'b0;
		leftExp = 1'b1;
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		repeat (6) @(posedge clock);
		`CHK(micStatus.leftSide, 1'b1)
		selectPin <= 1'b0;
		wakeUp();
		`CHK(micStatus.leftSide, 1'b1)
		conclude();
	end
endmodule
